//--- src/cpx_main.sv
// Operation
// - memory destination: operand register to memory, longs where long-aligned with four bytes left, else words
// - coprocessor destination: memory to operand register
// - control modes use ascending addresses
// - postincrement ascends, register grows per operand
// - predecrement: operands descend, bytes ascend
// - status transfer only in general category
// - bit 8 selects scan counter transfer too
// - status alone: 16-bit write or load
// - to coprocessor: scan counter first, then status
// - from coprocessor: status first, then scan counter
// - load from coprocessor flushes and refills prefetch
// - flow trace at start arms trace at completion of a load from coprocessor
// - loaded trace bits wait for next instruction
// - decode pre-instruction exception primitive fields
// - acknowledge mask to control, then take exception
// - pre-instruction exception uses four-word frame
// - stacked address is the operation word
// - coprocessor may reject unknown command this way
// - coprocessor avoids it after visible changes
// - coprocessor may release early, finish concurrently
// - concurrent fault reported at next instruction start
// - coprocessor records address via pass flag
// - operand count is mask population count
`timescale 1ns/10ps
`include "cpx_consts.svh"
module cpx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0]      wp;
	logic [AW:0]      rp;

	// depth must be a power of two for the wrap bit to work
	assign in_ready  = (wp - rp) != (AW+1)'(DEPTH);
	assign out_valid = wp != rp;
	assign out_data  = store[rp[AW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (in_valid && in_ready)
			store[wp[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (in_valid && in_ready)
				wp <= wp + 1'b1;
			if (out_valid && out_ready)
				rp <= rp + 1'b1;
		end
	end
endmodule: cpx_fifo

module cpx_main import cpx_pkg::*; #(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	cpx_if.main              cir,
	input  wire logic        ins_start,
	input  wire logic        ins_cond,
	input  wire logic [15:0] ins_cmd,
	input  wire logic [31:0] ins_addr,
	input  wire logic [31:0] ins_scan,
	input  wire logic [15:0] sr_in,
	input  wire cpx_ea_t     ea_mode,
	input  wire logic [31:0] ea_addr,
	input  wire logic [31:0] an_in,
	output logic             mem_req,
	output logic             mem_we,
	output logic             mem_long,
	output logic [31:0]      mem_addr,
	output logic [31:0]      mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             busy,
	output logic [15:0]      sr_out,
	output logic [31:0]      scan_out,
	output logic             trace_mode_flow,
	output logic [31:0]      an_out,
	output logic             an_we,
	output logic             flush,
	output logic [31:0]      refill_addr,
	output logic             refill_super,
	output logic             trace_take,
	output logic             exc_take,
	output logic [7:0]       exc_vector,
	output logic [3:0]       exc_format,
	output logic [31:0]      exc_pc,
	output logic             proto_viol,
	output logic             ins_done
);
	cpx_state_t  state;
	logic [15:0] prim;
	logic        cond;
	logic [31:0] iaddr;
	logic        trace_arm;
	logic [4:0]  opnd_left;
	logic [7:0]  byte_left;
	logic [31:0] cur;
	logic        acc_req;
	logic        acc_we;
	logic        acc_long;
	cpx_cir_t    acc_sel;
	logic [31:0] acc_wdata;
	logic        fi_ready;
	logic        fo_valid;
	cpx_unit_t   fo;

	function automatic logic [4:0] cpx_ones(input logic [15:0] m);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 16; i++)
			n = n + {4'h0, m[i]};
		return n;
	endfunction: cpx_ones

	// primitive decode
	wire dir      = prim[`CPX_DIR_BIT];
	wire scan_sel = prim[`CPX_SCAN_BIT];
	wire is_mcr   = prim[12:8] == `CPX_MCR_CODE;
	wire is_srs   = prim[12:9] == `CPX_SRS_CODE;
	wire is_pre   = !prim[`CPX_CA_BIT] && !dir && prim[12:8] == `CPX_PRE_CODE;
	wire is_null  = prim[12:8] == `CPX_NULL_CODE;
	wire [7:0] len = prim[7:0];
	wire [4:0] mask_cnt = cpx_ones(cir.rdata[15:0]);

	// transfer sequencing: long units only on long-aligned addresses
	wire       in_xfer  = state == st_xfer;
	wire       ul       = byte_left >= {5'h00, `CPX_LONG_BYTES} && !cur[1];
	wire [2:0] usz      = ul ? `CPX_LONG_BYTES : `CPX_WORD_BYTES;
	wire       src_req  = in_xfer && opnd_left != 5'h00 && fi_ready;
	wire       src_ack  = dir ? cir.ack : mem_ack;
	wire       src_fire = src_req && src_ack;
	wire       snk_ack  = dir ? mem_ack : cir.ack;
	wire [31:0] src_data = dir ? cir.rdata : mem_rdata;
	wire cpx_unit_t fi = '{addr: cur, long_sz: ul, data: src_data};
	wire       op_last  = byte_left == {5'h00, usz};
	wire       xfer_end = in_xfer && opnd_left == 5'h00 && !fo_valid;

	cpx_fifo #(.WIDTH($bits(cpx_unit_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.in_valid  (src_fire),
		.in_ready  (fi_ready),
		.in_data   (fi),
		.out_valid (fo_valid),
		.out_ready (in_xfer && snk_ack),
		.out_data  (fo)
	);

	// port steering: the fifo decouples source and sink sides
	assign cir.req     = in_xfer ? (dir ? src_req : fo_valid) : acc_req;
	assign cir.sel     = in_xfer ? cir_opnd : acc_sel;
	assign cir.we      = in_xfer ? !dir : acc_we;
	assign cir.long_sz = in_xfer ? (dir ? ul : fo.long_sz) : acc_long;
	// operand reads keep wdata still while the fifo drains underneath
	assign cir.wdata   = in_xfer ? (dir ? 32'h0000_0000 : fo.data) : acc_wdata;
	assign mem_req     = in_xfer && (dir ? fo_valid : src_req);
	assign mem_we      = in_xfer && dir;
	assign mem_addr    = dir ? fo.addr : cur;
	assign mem_long    = dir ? fo.long_sz : ul;
	assign mem_wdata   = fo.data;
	assign busy        = state != st_idle;

	// single accesses outside the bulk transfer
	always_comb begin
		acc_req   = 1'b1;
		acc_we    = 1'b0;
		acc_long  = 1'b0;
		acc_sel   = cir_resp;
		acc_wdata = 32'h0000_0000;
		case (state)
			st_cmd: begin
				acc_sel   = cond ? cir_cond : cir_cmd;
				acc_we    = 1'b1;
				acc_wdata = {16'h0000, ins_cmd};
			end
			st_resp: acc_sel = cir_resp;
			st_pass: begin
				acc_sel   = cir_iaddr;
				acc_we    = 1'b1;
				acc_long  = 1'b1;
				acc_wdata = iaddr;
			end
			st_rsel: acc_sel = cir_regsel;
			st_sr_iawr: begin
				acc_sel   = cir_iaddr;
				acc_we    = 1'b1;
				acc_long  = 1'b1;
				acc_wdata = scan_out;
			end
			st_sr_opwr: begin
				acc_sel   = cir_opnd;
				acc_we    = 1'b1;
				acc_wdata = {16'h0000, sr_out};
			end
			st_sr_oprd: acc_sel = cir_opnd;
			st_sr_iard: begin
				acc_sel  = cir_iaddr;
				acc_long = 1'b1;
			end
			st_xack: begin
				acc_sel   = cir_ctrl;
				acc_we    = 1'b1;
				acc_wdata = {16'h0000, `CPX_CTRL_XACK};
			end
			default: acc_req = 1'b0;
		endcase
	end

	// operand and address register walk
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			opnd_left <= 5'h00;
			byte_left <= 8'h00;
			cur       <= 32'h0000_0000;
			an_out    <= 32'h0000_0000;
		end else if (state == st_rsel && cir.ack) begin
			opnd_left <= (len == 8'h00) ? 5'h00 : mask_cnt;
			byte_left <= len;
			if (ea_mode == cpx_ea_predec && mask_cnt != 5'h00) begin
				cur    <= an_in - {24'h000000, len};
				an_out <= an_in - {24'h000000, len};
			end else begin
				cur    <= (ea_mode == cpx_ea_ctrl) ? ea_addr : an_in;
				an_out <= an_in;
			end
		end else if (src_fire) begin
			if (op_last) begin
				opnd_left <= opnd_left - 5'h01;
				byte_left <= len;
				if (ea_mode == cpx_ea_predec && opnd_left != 5'h01) begin
					cur    <= an_out - {24'h000000, len};
					an_out <= an_out - {24'h000000, len};
				end else begin
					cur <= cur + {29'h0, usz};
					if (ea_mode == cpx_ea_postinc)
						an_out <= cur + {29'h0, usz};
				end
			end else begin
				byte_left <= byte_left - {5'h00, usz};
				cur       <= cur + {29'h0, usz};
			end
		end
	end

	// primitive sequencer
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= st_idle;
			prim <= 16'h0000;
			cond <= 1'b0;
			iaddr <= 32'h0000_0000;
			sr_out <= `CPX_SR_RST;
			scan_out <= 32'h0000_0000;
			trace_mode_flow <= 1'b0;
			trace_arm <= 1'b0;
			an_we <= 1'b0;
			flush <= 1'b0;
			refill_addr <= 32'h0000_0000;
			refill_super <= 1'b0;
			trace_take <= 1'b0;
			exc_take <= 1'b0;
			exc_vector <= 8'h00;
			exc_format <= `CPX_FRAME_FOUR;
			exc_pc <= 32'h0000_0000;
			proto_viol <= 1'b0;
			ins_done <= 1'b0;
		end else begin
			{an_we, flush, trace_take, exc_take, proto_viol, ins_done} <= 6'h00;
			case (state)
				st_idle: if (ins_start) begin
					cond     <= ins_cond;
					iaddr    <= ins_addr;
					sr_out   <= sr_in;
					scan_out <= ins_scan;
					// trace mode frozen for the whole instruction
					trace_mode_flow <= sr_in[`CPX_TRACE_HI:`CPX_TRACE_LO] == `CPX_TRACE_FLOW;
					trace_arm <= 1'b0;
					state    <= st_cmd;
				end
				st_cmd: if (cir.ack) state <= st_resp;
				st_resp: if (cir.ack) begin
					prim  <= cir.rdata[15:0];
					state <= st_decode;
				end
				st_decode: state <= prim[`CPX_PASS_BIT] ? st_pass : st_exec;
				st_pass: if (cir.ack) state <= st_exec;
				st_exec: begin
					if (is_pre)
						state <= st_xack;
					else if (is_mcr)
						state <= (cond || len[0]) ? st_viol : st_rsel;
					else if (is_srs && cond)
						state <= st_viol;
					else if (is_srs)
						state <= dir ? st_sr_oprd : (scan_sel ? st_sr_iawr : st_sr_opwr);
					else if (is_null)
						state <= st_pend;
					else
						state <= st_viol;
				end
				st_viol: begin
					proto_viol <= 1'b1;
					state      <= st_idle;
				end
				st_rsel: if (cir.ack) state <= st_xfer;
				st_xfer: if (xfer_end) begin
					an_we <= ea_mode != cpx_ea_ctrl;
					state <= st_pend;
				end
				st_sr_iawr: if (cir.ack) state <= st_sr_opwr;
				st_sr_opwr: if (cir.ack) state <= st_pend;
				st_sr_oprd: if (cir.ack) begin
					sr_out <= cir.rdata[15:0];
					state  <= scan_sel ? st_sr_iard : st_flush;
				end
				st_sr_iard: if (cir.ack) begin
					scan_out <= cir.rdata;
					state    <= st_flush;
				end
				st_flush: begin
					flush        <= 1'b1;
					refill_addr  <= scan_out;
					refill_super <= sr_out[`CPX_SUPER_BIT];
					if (trace_mode_flow)
						trace_arm <= 1'b1;
					state <= st_pend;
				end
				st_xack: if (cir.ack) begin
					exc_take   <= 1'b1;
					exc_vector <= prim[7:0];
					exc_format <= `CPX_FRAME_FOUR;
					exc_pc     <= iaddr;
					state      <= st_idle;
				end
				st_pend: begin
					if (prim[`CPX_CA_BIT]) begin
						state <= st_resp;
					end else begin
						ins_done   <= 1'b1;
						trace_take <= trace_arm;
						state      <= st_idle;
					end
				end
				default: state <= st_idle;
			endcase
		end
	end
endmodule: cpx_main

//--- inc/cpx_consts.svh
`ifndef CPX_CONSTS_SVH
`define CPX_CONSTS_SVH
// primitive word fields
`define CPX_CA_BIT      15
`define CPX_PASS_BIT    14
`define CPX_DIR_BIT     13
`define CPX_SCAN_BIT    8
`define CPX_MCR_CODE    5'h01
`define CPX_SRS_CODE    4'h1
`define CPX_PRE_CODE    5'h1c
`define CPX_NULL_CODE   5'h08
// status register fields
`define CPX_TRACE_HI    15
`define CPX_TRACE_LO    14
`define CPX_TRACE_FLOW  2'h1
`define CPX_SUPER_BIT   13
`define CPX_SR_RST      16'h2700
// control interface register masks
`define CPX_CTRL_XACK   16'h0002
// stack frame format code for the four-word frame
`define CPX_FRAME_FOUR  4'h0
// transfer unit sizes in bytes
`define CPX_LONG_BYTES  3'h4
`define CPX_WORD_BYTES  3'h2
`endif

//--- inc/cpx_pkg.sv
package cpx_pkg;
	typedef enum logic [3:0] {
		cir_resp, cir_ctrl, cir_save, cir_restore, cir_opword,
		cir_cmd, cir_cond, cir_opnd, cir_regsel, cir_iaddr
	} cpx_cir_t;

	typedef enum logic [1:0] {cpx_ea_ctrl, cpx_ea_postinc, cpx_ea_predec} cpx_ea_t;

	typedef enum logic [3:0] {
		st_idle, st_cmd, st_resp, st_decode, st_pass, st_exec, st_viol, st_rsel, st_xfer,
		st_sr_iawr, st_sr_opwr, st_sr_oprd, st_sr_iard, st_flush, st_xack, st_pend
	} cpx_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic        long_sz;
		logic [31:0] data;
	} cpx_unit_t;
endpackage: cpx_pkg

//--- inc/cpx_if.sv
`timescale 1ns/10ps
interface cpx_if (
	input wire logic clk_sys,
	input wire logic nrst
);
	import cpx_pkg::*;
	logic        req;
	logic        we;
	logic        long_sz;
	cpx_cir_t    sel;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        ack;

	modport main (output req, output we, output long_sz, output sel, output wdata, input rdata, input ack);
	modport copro (input req, input we, input long_sz, input sel, input wdata, output rdata, output ack);
endinterface: cpx_if

//--- src/cpx_copro.sv
`timescale 1ns/10ps
`include "cpx_consts.svh"
module cpx_copro import cpx_pkg::*; #(
	parameter logic [15:0] CMD_MASK  = 16'h0000,
	parameter logic [15:0] CMD_MATCH = 16'h0000,
	parameter logic [7:0]  UNREC_VEC = 8'h0b
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	cpx_if.copro             cir,
	input  wire logic [15:0] prim_in,
	input  wire logic        prim_load,
	output logic             prim_ready,
	output logic             prim_refused,
	output logic [15:0]      cmd_word,
	output logic             cmd_is_cond,
	output logic             cmd_strobe,
	input  wire logic [15:0] regsel_in,
	input  wire logic [31:0] iaddr_in,
	output logic [31:0]      iaddr_cap,
	input  wire logic [31:0] op_rd_data,
	input  wire logic        op_rd_valid,
	output logic             op_rd_ready,
	output logic [31:0]      op_wr_data,
	output logic             op_wr_strobe,
	output logic [15:0]      ctrl_word,
	output logic             ctrl_strobe,
	input  wire logic        fault,
	input  wire logic [7:0]  fault_vec,
	input  wire logic        recover,
	output logic             released
);
	logic [15:0] resp;
	logic        resp_full;
	logic        altered;
	logic        first_prim;
	logic        fault_pend;
	logic [7:0]  fault_vec_l;
	logic        ack;
	logic [31:0] rdata;

	// an access is answered only once its data exists
	wire can_ans   = (cir.sel == cir_resp) ? resp_full :
		(cir.sel == cir_opnd && !cir.we) ? op_rd_valid : 1'b1;
	wire fire      = cir.req && !ack && can_ans;
	wire cmd_fire  = fire && cir.we && (cir.sel == cir_cmd || cir.sel == cir_cond);
	wire resp_fire = fire && !cir.we && cir.sel == cir_resp;
	wire unrec     = (cir.wdata[15:0] & CMD_MASK) != CMD_MATCH;
	wire fault_now = fault_pend || fault;
	wire [7:0] f_vec = fault_pend ? fault_vec_l : fault_vec;
	wire in_is_pre = !prim_in[`CPX_CA_BIT] && !prim_in[`CPX_DIR_BIT] && prim_in[12:8] == `CPX_PRE_CODE;
	wire load_ok   = prim_load && prim_ready;

	assign prim_ready  = !resp_full && !cmd_fire;
	assign op_rd_ready = fire && !cir.we && cir.sel == cir_opnd;
	assign cir.ack     = ack;
	assign cir.rdata   = rdata;

	// bus answer and captured writes
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ack          <= 1'b0;
			rdata        <= 32'h0000_0000;
			cmd_word     <= 16'h0000;
			cmd_is_cond  <= 1'b0;
			cmd_strobe   <= 1'b0;
			iaddr_cap    <= 32'h0000_0000;
			op_wr_data   <= 32'h0000_0000;
			op_wr_strobe <= 1'b0;
			ctrl_word    <= 16'h0000;
			ctrl_strobe  <= 1'b0;
		end else begin
			ack          <= fire;
			cmd_strobe   <= cmd_fire;
			op_wr_strobe <= fire && cir.we && cir.sel == cir_opnd;
			ctrl_strobe  <= fire && cir.we && cir.sel == cir_ctrl;
			if (cmd_fire) begin
				cmd_word    <= cir.wdata[15:0];
				cmd_is_cond <= cir.sel == cir_cond;
			end
			if (fire && cir.we && cir.sel == cir_opnd)
				op_wr_data <= cir.wdata;
			if (fire && cir.we && cir.sel == cir_ctrl)
				ctrl_word <= cir.wdata[15:0];
			if (fire && cir.we && cir.sel == cir_iaddr)
				iaddr_cap <= cir.wdata;
			if (fire && !cir.we) begin
				if (cir.sel == cir_resp)
					rdata <= {16'h0000, resp};
				else if (cir.sel == cir_opnd)
					rdata <= op_rd_data;
				else if (cir.sel == cir_regsel)
					rdata <= {16'h0000, regsel_in};
				else if (cir.sel == cir_iaddr)
					rdata <= iaddr_in;
				else
					rdata <= 32'h0000_0000;
			end
		end
	end

	// response register, fault holding and instruction tracking
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			resp         <= 16'h0000;
			resp_full    <= 1'b0;
			altered      <= 1'b0;
			first_prim   <= 1'b0;
			fault_pend   <= 1'b0;
			fault_vec_l  <= 8'h00;
			released     <= 1'b0;
			prim_refused <= 1'b0;
		end else begin
			prim_refused <= 1'b0;
			// a fault in the consuming cycle is used at once; if one is already held, the held vector is used and the new fault is dropped
			fault_pend   <= fault_now && !cmd_fire;
			if (fault)
				fault_vec_l <= fault_vec;
			if (fire && cir.sel == cir_opnd)
				altered <= 1'b1;
			if (cmd_fire) begin
				altered    <= 1'b0;
				released   <= 1'b0;
				first_prim <= cir.sel == cir_cmd;
				if (fault_now) begin
					resp      <= {3'h0, `CPX_PRE_CODE, f_vec};
					resp_full <= 1'b1;
				end else if (unrec) begin
					resp      <= {3'h0, `CPX_PRE_CODE, UNREC_VEC};
					resp_full <= 1'b1;
				end
			end else if (resp_fire) begin
				resp_full <= 1'b0;
				if (!resp[`CPX_CA_BIT] && !cmd_is_cond)
					released <= 1'b1;
			end else if (load_ok) begin
				first_prim <= 1'b0;
				// restarting after a visible change would corrupt state
				if (in_is_pre && altered) begin
					prim_refused <= 1'b1;
				end else begin
					resp      <= prim_in | {1'b0, first_prim && recover, 14'h0000};
					resp_full <= 1'b1;
				end
			end
		end
	end
endmodule: cpx_copro

//--- testbench/cpx_cir_assertions.sv
`timescale 1ns/10ps
`include "cpx_consts.svh"
module cpx_cir_assertions import cpx_pkg::*; (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        req,
	input wire logic        we,
	input wire logic        long_sz,
	input wire cpx_cir_t    sel,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic        ack
);
	default clocking dcb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// an answered command or condition write, and the response read
	sequence s_cmd_acc;
		ack && we && (sel == cir_cmd || sel == cir_cond);
	endsequence
	sequence s_resp_rd;
		req && !we && !long_sz && sel == cir_resp;
	endsequence
	// bus handshake: hold until ack, single ack pulse
	req_hold_a: assert property (req && !ack |=> req && $stable(sel) && $stable(we) && $stable(wdata))
		else $error("request changed before ack");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	ack_req_a: assert property (ack |-> req)
		else $error("ack without request");
	// fault reporting needs the response read right after the command
	resp_after_a: assert property (s_cmd_acc |-> ##[1:4] s_resp_rd)
		else $error("no response read after command");
	resp_word_a: assert property (req && sel == cir_resp |-> !we && !long_sz)
		else $error("response access not a word read");
	iaddr_long_a: assert property (req && sel == cir_iaddr |-> long_sz)
		else $error("address register access not long");
	xack_mask_a: assert property (req && sel == cir_ctrl |-> we && wdata[15:0] == `CPX_CTRL_XACK)
		else $error("bad control write");
	mask_read_a: assert property (req && sel == cir_regsel |-> !we && !long_sz)
		else $error("mask access not a word read");
endmodule: cpx_cir_assertions

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`include "cpx_consts.svh"
module tb_top import cpx_pkg::*;;
	logic        clk_sys, nrst, ins_start, ins_cond, mem_ack, prim_load, op_rd_valid, fault, recover;
	logic [15:0] ins_cmd, sr_in, prim_in, regsel_in, sr_out, cmd_word, ctrl_word, cw;
	logic [31:0] ins_addr, ins_scan, ea_addr, an_in, mem_rdata, iaddr_in, op_rd_data, fa, d, e;
	logic [31:0] mem_addr, mem_wdata, scan_out, an_out, refill_addr, exc_pc, iaddr_cap, op_wr_data;
	logic        mem_req, mem_we, mem_long, busy, trace_mode_flow, an_we, flush, refill_super, trace_take;
	logic        exc_take, proto_viol, ins_done, prim_ready, prim_refused, cmd_is_cond, cmd_strobe;
	logic        op_rd_ready, op_wr_strobe, ctrl_strobe, released;
	logic [7:0]  fault_vec, exc_vector, v;
	logic [3:0]  exc_format;
	cpx_ea_t     ea_mode;
	logic [31:0] seed = 32'h2e;
	logic [31:0] cq[$], wq[$], ma[$], md[$], ea[$];
	logic        ml[$], el[$];
	logic [15:0] pq[$];
	int          errors, check_count, n, len;
	bit          dn, ex, pv, tt, fl, aw, fs, rf, uc;

	cpx_if cpx_if_i (.clk_sys, .nrst);
	cpx_main #(.FIFO_DEPTH(32)) cpx_main_i (.clk_sys, .nrst, .cir(cpx_if_i), .ins_start, .ins_cond, .ins_cmd,
		.ins_addr, .ins_scan, .sr_in, .ea_mode, .ea_addr, .an_in, .mem_req, .mem_we, .mem_long, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack, .busy, .sr_out, .scan_out, .trace_mode_flow, .an_out, .an_we,
		.flush, .refill_addr, .refill_super, .trace_take, .exc_take, .exc_vector, .exc_format, .exc_pc,
		.proto_viol, .ins_done);
	cpx_copro #(.CMD_MASK(16'h8000), .CMD_MATCH(16'h0000), .UNREC_VEC(8'h0b)) cpx_copro_i (.clk_sys, .nrst,
		.cir(cpx_if_i), .prim_in, .prim_load, .prim_ready, .prim_refused,
		.cmd_word, .cmd_is_cond, .cmd_strobe, .regsel_in, .iaddr_in, .iaddr_cap, .op_rd_data, .op_rd_valid,
		.op_rd_ready, .op_wr_data, .op_wr_strobe, .ctrl_word, .ctrl_strobe, .fault, .fault_vec, .recover,
		.released);
	cpx_cir_assertions cpx_cir_assertions_i (.clk_sys, .nrst, .req(cpx_if_i.req), .we(cpx_if_i.we),
		.long_sz(cpx_if_i.long_sz), .sel(cpx_if_i.sel), .wdata(cpx_if_i.wdata), .rdata(cpx_if_i.rdata),
		.ack(cpx_if_i.ack));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction: xs

	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask: chk

	task automatic complete_run();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask: complete_run

	// expected memory units: long only when aligned and four bytes remain
	task automatic exp_units();
		logic [31:0] a;
		int          b;
		ea.delete();
		el.delete();
		n = $countones(regsel_in);
		for (int k = 0; k < n; k++) begin
			a = ea_mode == cpx_ea_predec ? an_in - (k + 1) * len : (ea_mode == cpx_ea_ctrl ? ea_addr : an_in) + k * len;
			b = len;
			while (b > 0) begin
				ea.push_back(a);
				el.push_back(b >= 4 && a[1] == 1'b0);
				a += el[$] ? 4 : 2;
				b -= el[$] ? 4 : 2;
			end
		end
	endtask: exp_units

	// one instruction; ld picks whether the bench loads the primitive
	task automatic run(input bit c, input logic [15:0] p, input bit ld);
		int i;
		cq.delete(); wq.delete(); ma.delete(); ml.delete(); md.delete();
		{dn, ex, pv, tt, fl, aw, rf} = '0;
		cw = '0;
		ins_start = 1;
		ins_cond = c;
		ins_cmd = {uc, 15'(xs())};
		ins_addr = xs();
		ins_scan = xs();
		@(negedge clk_sys);
		ins_start = 0;
		for (i = 0; ld && prim_ready !== 1'b1 && i < 200; i++) @(negedge clk_sys);
		if (i >= 200) begin
			chk(1'b0, "no primitive slot");
			complete_run();
		end
		if (ld) begin
			prim_in = p;
			prim_load = 1;
			@(negedge clk_sys);
			prim_load = 0;
		end
		for (i = 0; !(dn || ex || pv) && i < 4000; i++) begin
			@(negedge clk_sys);
			if (flush) {fl, fa, fs} = {1'b1, refill_addr, refill_super};
			if (ctrl_strobe) cw = ctrl_word;
			if (cmd_strobe) chk(cmd_word === ins_cmd && cmd_is_cond === c, "command word");
			{tt, aw} = {tt | trace_take, aw | an_we};
			{dn, ex, pv} = {ins_done, exc_take, proto_viol};
			// further primitives go in only after an operand was written
			rf |= prim_refused;
			prim_load = pq.size() > 0 && wq.size() > 0 && prim_ready === 1'b1 && !prim_load;
			if (prim_load) prim_in = pq.pop_front();
		end
		if (i >= 4000) begin
			chk(1'b0, "instruction hang");
			complete_run();
		end
		repeat (2) @(negedge clk_sys);
	endtask: run

	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end

	// memory answers at random so the fifo path stalls
	always @(negedge clk_sys) begin
		mem_ack <= 1'b0;
		if (mem_req === 1'b1 && !mem_ack && xs() > 32'h7fffffff) begin
			mem_ack <= 1'b1;
			mem_rdata <= seed;
			ma.push_back(mem_addr);
			ml.push_back(mem_long);
			md.push_back(mem_we ? mem_wdata : seed);
		end
		op_rd_valid <= xs() > 32'h5fffffff;
		op_rd_data <= seed;
	end

	// log operand values consumed and written by the coprocessor end
	always @(posedge clk_sys) begin
		if (op_rd_ready && op_rd_valid) cq.push_back(op_rd_data);
		if (op_wr_strobe) wq.push_back(op_wr_data);
	end

	initial begin
		{nrst, ins_start, ins_cond, prim_load, fault, recover, ins_cmd, sr_in, prim_in} = '0;
		{ins_addr, ins_scan, ea_addr, an_in, iaddr_in, regsel_in, fault_vec} = '0;
		ea_mode = cpx_ea_ctrl;
		repeat (3) @(negedge clk_sys);
		nrst = 1;
		chk(sr_out === `CPX_SR_RST, "status reset");
		// early release with address capture
		recover = 1;
		run(0, 16'h0800, 1);
		chk(dn && released === 1'b1, "release");
		chk(iaddr_cap === ins_addr, "pass address");
		recover = 0;
		// status register out, alone and after the scan counter
		for (int s = 0; s < 2; s++) begin
			sr_in = 16'(xs());
			run(0, s ? 16'h0300 : 16'h0200, 1);
			chk(dn && wq.size() == 1 && wq[0][15:0] === sr_in, "status out");
			if (s) chk(iaddr_cap === ins_scan, "scan out");
		end
		// status register in; trace follows the mode at start only
		for (int s = 0; s < 4; s++) begin
			sr_in = {s[1:0], 14'(xs())};
			iaddr_in = xs() & 32'hfffffffe;
			run(0, s[1] ? 16'h2300 : 16'h2200, 1);
			chk(dn && sr_out === cq[0][15:0], "status in");
			chk(fl && fa === (s[1] ? iaddr_in : ins_scan) && fs === sr_out[13], "refill");
			if (s[1]) chk(scan_out === iaddr_in, "scan in");
			chk(tt === (s == 1) && trace_mode_flow === (s == 1), "trace");
		end
		run(1, 16'h0200, 1);
		chk(pv, "conditional status");
		// restart refused after a visible change, then a plain release
		pq = '{16'h1c00, 16'h0800};
		run(0, 16'h8200, 1);
		chk(dn && rf && !ex && wq[0][15:0] === sr_in && busy === 1'b0, "refused exception");
		// exception from both categories, then a held fault
		for (int s = 0; s < 3; s++) begin
			v = 8'(xs());
			fault_vec = v;
			fault = (s == 2);
			@(negedge clk_sys);
			fault = 0;
			run(s[0], 16'h1c00 | v, s < 2);
			chk(ex && exc_vector === v && exc_format === `CPX_FRAME_FOUR, "exception");
			chk(exc_pc === ins_addr && cw === `CPX_CTRL_XACK, "exception pc");
		end
		// unknown command answered with the restart exception
		uc = 1;
		run(0, 16'h0000, 0);
		chk(ex && exc_vector === 8'h0b && cw === `CPX_CTRL_XACK, "unknown command");
		uc = 0;
		// multiple operand transfers over all legal mode and direction pairs
		for (int s = 0; s < 4; s++) begin
			len = 4 + 2 * int'(xs() % 5);
			regsel_in = 16'(xs());
			ea_mode = s < 2 ? cpx_ea_ctrl : (s == 2 ? cpx_ea_postinc : cpx_ea_predec);
			ea_addr = xs() & 32'hfffffffe;
			an_in = xs() & 32'hfffffffe;
			run(0, {2'b00, s[0], 5'h01, len[7:0]}, 1);
			exp_units();
			chk(dn && ma.size() == ea.size() && (s[0] ? cq.size() : wq.size()) == ea.size(), "unit count");
			for (int k = 0; k < ea.size(); k++) begin
				d = s[0] ? cq[k] : md[k];
				e = s[0] ? md[k] : wq[k];
				chk(ma[k] === ea[k] && ml[k] === el[k] && (el[k] ? d === e : d[15:0] === e[15:0]), "unit");
			end
			if (s > 1) chk(aw && an_out === (s == 2 ? an_in + n * len : an_in - n * len), "address reg");
		end
		complete_run();
	end
endmodule: tb_top
